/* verilog/osic_seq_ctrl.sv */
// Output turn-off sequencing, power-up gating and bus unlock control
// Operation
// - Run pin low or bus off command starts the controlled turn-off ramp.
// - Fault shutdown or enabled external fault line tri-states output, no ramp.
// - Falling ramp is actively followed only in forced continuous mode.
// - At end of fall interval stop sinking current; load decays output.
// - Discontinuous mode never sinks negative current during turn-off.
// - Fall time is clamped to at most 1.3 seconds.
// - Ramp steps once per 0.1ms; steps equal fall time over interval.
// - External driver supply chosen only above 4.7V with input above 7V.
// - Run line held low until initialization supplies are all good.
// - Sequencing waits for the input turn-on comparator after initialization.
// - Below input turn-off threshold pull shared clock low; restart needs turn-on.
// - Fault line low at input power-up raises alert regardless of mask.
// - Partial bus transaction from before reset flags communication fault, alert.
// - Logic supply alone runs digital section and accepts bus transactions.
// - Input never applied drives common status bit 3 low.
// - Not initialized, answer only addresses 5A and 5B.
// - Two unlock writes of BD to 5B enable the configured address.
// - Run line released only after initialization and input above turn-on.
`timescale 1ns/1ns
`include "osic_defines.svh"
module osic_seq_ctrl
  import osic_pkg::*;
#(
  parameter int TICK_CYCLES = `OSIC_STEP_NS / `OSIC_CLK_NS,
  parameter int VW = 12
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [`OSIC_AW-1:0] addr_in,
  input wire logic [`OSIC_DW-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`OSIC_DW-1:0] rd_data_out,
  input wire logic run_pin_in,
  input wire logic fault_line_in,
  input wire logic input_turn_on_threshold_cmp_in,
  input wire logic vin_below_off_in,
  input wire logic ext_supply_ok_in,
  input wire logic vin_above_7v_in,
  input wire logic init_ok_in,
  input wire logic vin_present_in,
  input wire logic fault_shutdown_in,
  input wire logic bus_start_in,
  input wire logic bus_stop_in,
  input wire logic bus_addr_valid_in,
  input wire logic [6:0] bus_addr_in,
  input wire logic bus_wr_in,
  input wire logic [7:0] bus_cmd_in,
  input wire logic [7:0] bus_data_in,
  input wire logic manufacturer_reset_command_cmd_in,
  output logic bus_addr_ack_out,
  output logic run_oe_out,
  output logic share_clk_oe_out,
  output logic alert_oe_out,
  output logic out_tristate_out,
  output logic sink_en_out,
  output logic pwm_enable_out,
  output logic adc_valid_out,
  output logic ext_supply_sel_out,
  output logic [VW-1:0] vout_target_out
);
  localparam int FALL_MAX = `OSIC_FALL_MAX_NS / `OSIC_STEP_NS;
  localparam logic [13:0] FALL_MAX_W = 14'(FALL_MAX);

  logic [7:0] pins;
  logic run_s;
  logic fault_line_s;
  logic fault_low_s;
  logic input_turn_on_threshold_s;
  logic input_turn_off_threshold_s;
  logic ext_ok_s;
  logic vin7_s;
  logic init_s;
  logic vin_pres_s;

  osic_pin_sync #(.W(8)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .pin_in({vin_present_in, init_ok_in, vin_above_7v_in, ext_supply_ok_in,
             vin_below_off_in, input_turn_on_threshold_cmp_in, ~fault_line_in, run_pin_in}),
    .level_out(pins)
  );
  assign {vin_pres_s, init_s, vin7_s, ext_ok_s, input_turn_off_threshold_s, input_turn_on_threshold_s, fault_low_s, run_s} = pins;
  // Fault line synced inverted so the flushed synchroniser reads as no fault
  assign fault_line_s = !fault_low_s;

  osic_state_t state;
  osic_state_t next_state;
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [VW-1:0] setpoint;
  logic [VW-1:0] next_setpoint;
  logic [15:0] delay_cfg;
  logic [15:0] next_delay_cfg;
  logic [13:0] fall_cfg;
  logic [13:0] next_fall_cfg;
  logic [6:0] cfg_addr;
  logic [6:0] next_cfg_addr;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [VW-1:0] next_target;
  logic vin_ok;
  logic next_vin_ok;
  logic vin_seen;
  logic next_vin_seen;
  logic comm_fault;
  logic next_comm_fault;
  logic pwrup_fault;
  logic next_pwrup_fault;
  logic start_seen;
  logic next_start_seen;
  logic unlock_half;
  logic next_unlock_half;
  logic unlocked;
  logic next_unlocked;
  logic need_reset;
  logic next_need_reset;
  logic [`OSIC_DW-1:0] next_rd_data;
  logic next_ack;
  logic tick;
  logic fault_trip;
  logic off_req;
  logic run_release;
  logic restricted;

  function automatic logic addr_hit(input logic [6:0] a, input logic restr,
                                    input logic [6:0] own);
    if (restr) begin
      addr_hit = (a == `OSIC_ADDR_GLOBAL_A) || (a == `OSIC_ADDR_GLOBAL_B);
    end else begin
      addr_hit = (a == own);
    end
  endfunction

  always_comb begin
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    fault_trip = fault_shutdown_in || (ctrl[`OSIC_CTRL_FAULT_RESP] && !fault_line_s);
    off_req = !run_s || !ctrl[`OSIC_CTRL_OP_ON];
    run_release = init_s && vin_ok;
    restricted = !vin_seen && !unlocked;
    next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    next_state = state;
    next_ctrl = ctrl;
    next_setpoint = setpoint;
    next_delay_cfg = delay_cfg;
    next_fall_cfg = fall_cfg;
    next_cfg_addr = cfg_addr;
    next_cnt = cnt;
    next_acc = acc;
    next_target = vout_target_out;
    next_comm_fault = comm_fault;
    next_pwrup_fault = pwrup_fault;
    next_start_seen = start_seen || bus_start_in;
    next_unlock_half = unlock_half;
    next_unlocked = unlocked;
    next_need_reset = need_reset;
    next_rd_data = '0;
    next_ack = 1'b0;
    // Input window: set on turn-on, cleared below turn-off
    next_vin_ok = input_turn_on_threshold_s ? 1'b1 : (input_turn_off_threshold_s ? 1'b0 : vin_ok);
    next_vin_seen = vin_seen || vin_pres_s;
    if (wr_in) begin
      case (addr_in)
        `OSIC_REG_CTRL: next_ctrl = wr_data_in[3:0];
        `OSIC_REG_SETPOINT: next_setpoint = wr_data_in[VW-1:0];
        `OSIC_REG_TURN_OFF_DELAY_TIME: next_delay_cfg = wr_data_in;
        `OSIC_REG_TURN_OFF_FALL_TIME: next_fall_cfg =
            (wr_data_in[13:0] > FALL_MAX_W) ? FALL_MAX_W : wr_data_in[13:0];
        `OSIC_REG_CFG_ADDR: next_cfg_addr = wr_data_in[6:0];
        `OSIC_REG_STATUS: begin
          if (wr_data_in[`OSIC_ST_COMM_FAULT]) next_comm_fault = 1'b0;
          if (wr_data_in[`OSIC_ST_PWRUP_FAULT]) next_pwrup_fault = 1'b0;
        end
        default: ;
      endcase
    end
    // Set after clear: a stop with no start since reset is a torn transfer
    if (bus_stop_in && !start_seen && !bus_start_in) begin
      next_comm_fault = 1'b1;
    end
    // Only the first power-up edge of the input checks the fault line
    if (vin_pres_s && !vin_seen && !fault_line_s) begin
      next_pwrup_fault = 1'b1;
    end
    if (bus_addr_valid_in) begin
      next_ack = addr_hit(bus_addr_in, restricted, cfg_addr);
    end
    if (bus_wr_in && restricted && bus_addr_in == `OSIC_ADDR_GLOBAL_B
        && bus_cmd_in == `OSIC_UNLOCK_CMD) begin
      if (bus_data_in == `OSIC_UNLOCK_KEY1) begin
        next_unlock_half = 1'b1;
      end else if (bus_data_in == `OSIC_UNLOCK_KEY2 && unlock_half) begin
        next_unlocked = 1'b1;
        next_need_reset = 1'b1;
      end else begin
        next_unlock_half = 1'b0;
      end
    end
    // Reset command only counts once input power is really there
    if (manufacturer_reset_command_cmd_in && vin_pres_s) begin
      next_need_reset = 1'b0;
    end
    if (rd_in) begin
      case (addr_in)
        `OSIC_REG_CTRL: next_rd_data = {12'h000, ctrl};
        `OSIC_REG_SETPOINT: next_rd_data = 16'(setpoint);
        `OSIC_REG_TURN_OFF_DELAY_TIME: next_rd_data = delay_cfg;
        `OSIC_REG_TURN_OFF_FALL_TIME: next_rd_data = {2'h0, fall_cfg};
        `OSIC_REG_CFG_ADDR: next_rd_data = {9'h000, cfg_addr};
        `OSIC_REG_STATUS: begin
          next_rd_data[`OSIC_ST_COMM_FAULT] = comm_fault;
          next_rd_data[`OSIC_ST_PWRUP_FAULT] = pwrup_fault;
          next_rd_data[`OSIC_ST_EXT_SEL] = ext_supply_sel_out;
          next_rd_data[`OSIC_ST_UNLOCKED] = unlocked;
          next_rd_data[`OSIC_ST_NEED_RESET] = need_reset;
          next_rd_data[`OSIC_ST_VIN_OK] = vin_ok;
          next_rd_data[`OSIC_ST_STATE_LSB +: 3] = state;
        end
        `OSIC_REG_COMMON: next_rd_data[`OSIC_COMMON_NVM_INIT] = vin_seen;
        default: next_rd_data = '0;
      endcase
    end
    case (state)
      OSIC_S_OFF: begin
        next_target = '0;
        if (run_release && run_s && ctrl[`OSIC_CTRL_OP_ON] && !fault_trip) begin
          next_state = OSIC_S_ON;
          next_target = setpoint;
        end
      end
      OSIC_S_ON: begin
        next_target = setpoint;
        if (fault_trip) begin
          next_state = OSIC_S_TRI;
        end else if (off_req) begin
          next_state = OSIC_S_DELAY;
          next_cnt = delay_cfg;
        end
      end
      OSIC_S_DELAY: begin
        if (fault_trip) begin
          next_state = OSIC_S_TRI;
        end else if (tick) begin
          if (cnt != 16'h0000) begin
            next_cnt = cnt - 16'h0001;
          end else if (fall_cfg == 14'h0000) begin
            next_state = OSIC_S_OFF;
            next_target = '0;
          end else begin
            next_state = OSIC_S_FALL;
            next_cnt = {2'h0, fall_cfg};
            next_acc = '0;
          end
        end
      end
      OSIC_S_FALL: begin
        // Owed decrements run beside the step count, so a busy cycle never loses a tick
        if (fault_trip) begin
          next_state = OSIC_S_TRI;
        end else if (tick && cnt == 16'h0001) begin
          next_state = OSIC_S_OFF;
          next_target = '0;
        end else begin
          if (vout_target_out != '0 && acc >= {2'h0, fall_cfg}) begin
            next_target = vout_target_out - VW'(1);
            next_acc = acc - {2'h0, fall_cfg};
          end
          if (tick) begin
            next_cnt = cnt - 16'h0001;
            next_acc = next_acc + 16'(setpoint);
          end
        end
      end
      OSIC_S_TRI: begin
        next_target = '0;
        if (!run_s && !fault_trip) begin
          next_state = OSIC_S_OFF;
        end
      end
      default: next_state = OSIC_S_OFF;
    endcase
    // Input collapse drops the channel and forces a fresh sequence
    if (!vin_ok && state != OSIC_S_OFF && state != OSIC_S_TRI) begin
      next_state = OSIC_S_TRI;
      next_target = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= OSIC_S_OFF;
      ctrl <= `OSIC_CTRL_RST;
      setpoint <= '0;
      delay_cfg <= 16'h0000;
      fall_cfg <= 14'h0000;
      cfg_addr <= `OSIC_CFG_ADDR_RST;
      tick_cnt <= 32'h0000_0000;
      cnt <= 16'h0000;
      acc <= 16'h0000;
      vin_ok <= 1'b0;
      vin_seen <= 1'b0;
      comm_fault <= 1'b0;
      pwrup_fault <= 1'b0;
      start_seen <= 1'b0;
      unlock_half <= 1'b0;
      unlocked <= 1'b0;
      need_reset <= 1'b0;
      rd_data_out <= '0;
      bus_addr_ack_out <= 1'b0;
      run_oe_out <= 1'b1;
      share_clk_oe_out <= 1'b0;
      alert_oe_out <= 1'b0;
      out_tristate_out <= 1'b1;
      sink_en_out <= 1'b0;
      pwm_enable_out <= 1'b0;
      adc_valid_out <= 1'b0;
      ext_supply_sel_out <= 1'b0;
      vout_target_out <= '0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      setpoint <= next_setpoint;
      delay_cfg <= next_delay_cfg;
      fall_cfg <= next_fall_cfg;
      cfg_addr <= next_cfg_addr;
      tick_cnt <= next_tick_cnt;
      cnt <= next_cnt;
      acc <= next_acc;
      vin_ok <= next_vin_ok;
      vin_seen <= next_vin_seen;
      comm_fault <= next_comm_fault;
      pwrup_fault <= next_pwrup_fault;
      start_seen <= next_start_seen;
      unlock_half <= next_unlock_half;
      unlocked <= next_unlocked;
      need_reset <= next_need_reset;
      rd_data_out <= next_rd_data;
      bus_addr_ack_out <= next_ack;
      run_oe_out <= !run_release;
      share_clk_oe_out <= !next_vin_ok;
      alert_oe_out <= next_comm_fault || next_pwrup_fault
                      || (!fault_line_s && !ctrl[`OSIC_CTRL_ALERT_MASK]);
      out_tristate_out <= (next_state == OSIC_S_TRI) || (next_state == OSIC_S_OFF);
      // Sinking only in forced continuous mode while the ramp runs
      sink_en_out <= (next_state == OSIC_S_FALL) && ctrl[`OSIC_CTRL_FCM];
      pwm_enable_out <= (next_state == OSIC_S_ON || next_state == OSIC_S_DELAY
                         || next_state == OSIC_S_FALL) && !next_need_reset;
      adc_valid_out <= vin_pres_s && !next_need_reset;
      ext_supply_sel_out <= ext_ok_s && vin7_s;
      vout_target_out <= next_target;
    end
  end
endmodule

/* shared/osic_defines.svh */
// Offsets, fields, reset values and timing figures of the sequencing block
`ifndef OSIC_DEFINES_SVH
`define OSIC_DEFINES_SVH
`define OSIC_AW 8
`define OSIC_DW 16
`define OSIC_REG_CTRL 8'h00
`define OSIC_REG_SETPOINT 8'h04
`define OSIC_REG_TURN_OFF_DELAY_TIME 8'h08
`define OSIC_REG_TURN_OFF_FALL_TIME 8'h0C
`define OSIC_REG_CFG_ADDR 8'h10
`define OSIC_REG_STATUS 8'h14
`define OSIC_REG_COMMON 8'h18
`define OSIC_CTRL_OP_ON 0
`define OSIC_CTRL_FAULT_RESP 1
`define OSIC_CTRL_FCM 2
`define OSIC_CTRL_ALERT_MASK 3
`define OSIC_CTRL_RST 4'h0
`define OSIC_CFG_ADDR_RST 7'h40
`define OSIC_ST_COMM_FAULT 0
`define OSIC_ST_PWRUP_FAULT 1
`define OSIC_ST_EXT_SEL 2
`define OSIC_ST_UNLOCKED 3
`define OSIC_ST_NEED_RESET 4
`define OSIC_ST_VIN_OK 5
`define OSIC_ST_STATE_LSB 8
`define OSIC_COMMON_NVM_INIT 3
`define OSIC_ADDR_GLOBAL_A 7'h5A
`define OSIC_ADDR_GLOBAL_B 7'h5B
`define OSIC_UNLOCK_CMD 8'hBD
`define OSIC_UNLOCK_KEY1 8'h2B
`define OSIC_UNLOCK_KEY2 8'hC4
`define OSIC_CLK_NS 4
`define OSIC_STEP_NS 100000
`define OSIC_FALL_MAX_NS 1300000000
`endif

/* shared/osic_pkg.sv */
// Types shared by the sequencing block
package osic_pkg;
  typedef enum logic [2:0] {
    OSIC_S_OFF,
    OSIC_S_ON,
    OSIC_S_DELAY,
    OSIC_S_FALL,
    OSIC_S_TRI
  } osic_state_t;
endpackage

/* verilog/osic_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module osic_pin_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // First stage feeds only the second
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level_out[i];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level_out <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= next_level;
    end
  end
endmodule

/* bench/osic_seq_ctrl_chk.sv */
// Port-level assertions for the sequencing block
`timescale 1ns/1ns
module osic_seq_ctrl_chk (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic rd_in,
  input wire logic [15:0] rd_data_out,
  input wire logic bus_addr_valid_in,
  input wire logic bus_addr_ack_out,
  input wire logic fault_shutdown_in,
  input wire logic out_tristate_out,
  input wire logic sink_en_out,
  input wire logic init_ok_in,
  input wire logic run_oe_out,
  input wire logic vin_below_off_in,
  input wire logic share_clk_oe_out,
  input wire logic ext_supply_ok_in,
  input wire logic vin_above_7v_in,
  input wire logic ext_supply_sel_out,
  input wire logic alert_oe_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_ack_cause; bus_addr_ack_out |-> $past(bus_addr_valid_in); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("address ack without a received address");
  property p_rd_idle; !$past(rd_in) |-> rd_data_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
  property p_fault_tri; fault_shutdown_in && !out_tristate_out |-> ##[1:3] out_tristate_out;
  endproperty
  a_fault_tri: assert property (p_fault_tri)
    else $error("fault did not three-state the output");
  property p_fault_nosink; fault_shutdown_in |-> ##[1:3] !sink_en_out; endproperty
  a_fault_nosink: assert property (p_fault_nosink)
    else $error("sinking during fault shutdown");
  property p_sink_drive; sink_en_out |-> !out_tristate_out; endproperty
  a_sink_drive: assert property (p_sink_drive)
    else $error("sinking while three-stated");
  property p_init_hold; !init_ok_in [*8] |-> run_oe_out; endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("run line released before init");
  property p_vin_clk; vin_below_off_in [*8] |-> share_clk_oe_out; endproperty
  a_vin_clk: assert property (p_vin_clk)
    else $error("shared clock not pulled low");
  property p_ext_sel; (ext_supply_ok_in && vin_above_7v_in) [*8] |-> ext_supply_sel_out;
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("external supply not selected");
  property p_int_sel; (!ext_supply_ok_in || !vin_above_7v_in) [*8] |-> !ext_supply_sel_out;
  endproperty
  a_int_sel: assert property (p_int_sel)
    else $error("external supply selected without both conditions");
  c_ack: cover property (bus_addr_ack_out);
  c_sink: cover property (sink_en_out);
  c_alert: cover property (alert_oe_out);
endmodule
bind osic_seq_ctrl osic_seq_ctrl_chk u_chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .bus_addr_valid_in(bus_addr_valid_in), .bus_addr_ack_out(bus_addr_ack_out),
  .fault_shutdown_in(fault_shutdown_in), .out_tristate_out(out_tristate_out),
  .sink_en_out(sink_en_out), .init_ok_in(init_ok_in), .run_oe_out(run_oe_out),
  .vin_below_off_in(vin_below_off_in), .share_clk_oe_out(share_clk_oe_out),
  .ext_supply_ok_in(ext_supply_ok_in), .vin_above_7v_in(vin_above_7v_in),
  .ext_supply_sel_out(ext_supply_sel_out), .alert_oe_out(alert_oe_out)
);

/* bench/osic_host_model.sv */
// Host controller model issuing decoded bus events
`timescale 1ns/1ns
module osic_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  output logic start_out,
  output logic stop_out,
  output logic av_out,
  output logic [6:0] addr_out,
  output logic wr_out,
  output logic [7:0] cmd_out,
  output logic [7:0] data_out,
  output logic mrst_out
);
  initial begin
    {start_out, stop_out, av_out, wr_out, mrst_out} = 5'h00;
    {addr_out, cmd_out, data_out} = 23'h000000;
  end
  task automatic addr_ph(input logic [6:0] a, output logic ack);
    @(posedge clk_in);
    start_out <= 1'b1;
    av_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    start_out <= 1'b0;
    av_out <= 1'b0;
    addr_out <= ~a;
    #1 ack = ack_in;
  endtask
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    cmd_out <= c;
    data_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    cmd_out <= ~c;
    data_out <= ~d;
  endtask
  task automatic unlock;
    wr_byte(7'h5B, 8'hBD, 8'h2B);
    wr_byte(7'h5B, 8'hBD, 8'hC4);
  endtask
  task automatic pulse_stop; // Stop with no start, as from a cut-off frame
    @(posedge clk_in);
    stop_out <= 1'b1;
    @(posedge clk_in);
    stop_out <= 1'b0;
  endtask
  task automatic pulse_mrst;
    @(posedge clk_in);
    mrst_out <= 1'b1;
    @(posedge clk_in);
    mrst_out <= 1'b0;
  endtask
endmodule

/* bench/osic_seq_ctrl_tb_top.sv */
// Self-checking bench for the sequencing block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module osic_seq_ctrl_tb_top;
  logic sys_clk_in = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b1, fline = 1'b1;
  logic von = 1'b0, voff = 1'b0, ext_ok = 1'b0, v7 = 1'b0, init_ok = 1'b0, vpres = 1'b0;
  logic fshut = 1'b0, start, stop, av, bwr, mrst, ack, run_oe, sclk_oe, alert, tri_st, sink;
  logic pwm, adc, ext_sel;
  logic [6:0] baddr;
  logic [7:0] addr = 8'h00, bcmd, bdata;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [11:0] tgt;
  int num_errors = 0, n_checks = 0, cycles = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  osic_seq_ctrl #(.TICK_CYCLES(10)) DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
    .run_pin_in(run), .fault_line_in(fline), .input_turn_on_threshold_cmp_in(von), .vin_below_off_in(voff),
    .ext_supply_ok_in(ext_ok), .vin_above_7v_in(v7), .init_ok_in(init_ok),
    .vin_present_in(vpres), .fault_shutdown_in(fshut), .bus_start_in(start),
    .bus_stop_in(stop), .bus_addr_valid_in(av), .bus_addr_in(baddr), .bus_wr_in(bwr),
    .bus_cmd_in(bcmd), .bus_data_in(bdata), .manufacturer_reset_command_cmd_in(mrst), .bus_addr_ack_out(ack),
    .run_oe_out(run_oe), .share_clk_oe_out(sclk_oe), .alert_oe_out(alert),
    .out_tristate_out(tri_st), .sink_en_out(sink), .pwm_enable_out(pwm), .adc_valid_out(adc),
    .ext_supply_sel_out(ext_sel), .vout_target_out(tgt));
  osic_host_model hm (.clk_in(sys_clk_in), .ack_in(ack), .start_out(start), .stop_out(stop),
    .av_out(av), .addr_out(baddr), .wr_out(bwr), .cmd_out(bcmd), .data_out(bdata),
    .mrst_out(mrst));
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n); // Pins need 4 edges through the synchroniser
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    logic [15:0] d;
    logic a;
    int k;
    repeat (20) @(posedge sys_clk_in);
    rstn <= 1'b1;
    cyc(10);
    `CHK("run hold", 1'b1, run_oe)
    rd_reg(8'h18, d);
    `CHK("common init", 1'b0, d[3])
    rd_reg(8'h1C, d);
    `CHK("unmapped", 16'h0000, d)
    hm.addr_ph(7'h40, a);
    `CHK("cfg ack locked", 1'b0, a)
    hm.addr_ph(7'h5A, a);
    `CHK("ack 5A", 1'b1, a)
    hm.addr_ph(7'h5B, a);
    `CHK("ack 5B", 1'b1, a)
    hm.wr_byte(7'h5B, 8'hBD, 8'h2B);
    hm.wr_byte(7'h5B, 8'hBD, 8'h00);
    rd_reg(8'h14, d);
    `CHK("bad key", 1'b0, d[3])
    hm.unlock();
    rd_reg(8'h14, d);
    `CHK("unlocked", 2'h3, d[4:3])
    hm.addr_ph(7'h40, a);
    `CHK("cfg ack open", 1'b1, a)
    @(posedge sys_clk_in);
    init_ok <= 1'b1;
    vpres <= 1'b1;
    cyc(8);
    `CHK("run wait vin", 1'b1, run_oe)
    `CHK("adc locked", 1'b0, adc)
    @(posedge sys_clk_in);
    von <= 1'b1;
    cyc(8);
    `CHK("run release", 1'b0, run_oe)
    hm.pulse_mrst();
    cyc(2);
    `CHK("adc valid", 1'b1, adc)
    wr_reg(8'h0C, 16'h3FFF);
    rd_reg(8'h0C, d);
    `CHK("fall clamp", 16'h32C8, d)
    wr_reg(8'h04, 16'h0064);
    wr_reg(8'h08, 16'h0001);
    wr_reg(8'h0C, 16'h0004);
    wr_reg(8'h00, 16'h0005);
    cyc(4);
    `CHK("on target", 12'h064, tgt)
    `CHK("pwm on", 1'b1, pwm)
    wr_reg(8'h00, 16'h0004);
    rd_reg(8'h14, d);
    `CHK("delay state", 3'h2, d[10:8])
    k = 0;
    while (sink !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    `CHK("delay len", 1'b1, k >= 5 && k <= 30)
    `CHK("fcm sink", 1'b1, sink)
    k = 0;
    while (sink === 1'b1 && k < 100) begin
      cyc(1);
      k++;
      if (k == 20) `CHK("mid ramp", 1'b1, tgt < 12'h064 && tgt > 12'h000)
    end
    `CHK("fall len", 1'b1, k >= 35 && k <= 45)
    cyc(2);
    `CHK("fall end", 12'h000, tgt)
    `CHK("off tri", 1'b1, tri_st)
    wr_reg(8'h00, 16'h0001);
    cyc(4);
    `CHK("dcm on", 1'b0, tri_st)
    @(posedge sys_clk_in);
    run <= 1'b0;
    a = 1'b0;
    repeat (120) begin
      cyc(1);
      if (sink === 1'b1) a = 1'b1;
    end
    `CHK("dcm no sink", 1'b0, a)
    rd_reg(8'h14, d);
    `CHK("run off", 3'h0, d[10:8])
    for (int i = 0; i < 2; i++) begin
      wr_reg(8'h00, 16'h0007);
      @(posedge sys_clk_in);
      run <= 1'b1;
      cyc(8);
      `CHK("on before fault", 1'b0, tri_st)
      @(posedge sys_clk_in);
      if (i == 0) fline <= 1'b0;
      else fshut <= 1'b1;
      cyc(8);
      rd_reg(8'h14, d);
      `CHK("fault tri", 3'h4, d[10:8])
      `CHK("fault sink", 1'b0, sink)
      @(posedge sys_clk_in);
      fline <= 1'b1;
      fshut <= 1'b0;
      run <= 1'b0;
      cyc(8);
    end
    @(posedge sys_clk_in);
    von <= 1'b0;
    voff <= 1'b1;
    cyc(8);
    `CHK("share clk low", 1'b1, sclk_oe)
    @(posedge sys_clk_in);
    voff <= 1'b0;
    cyc(8);
    `CHK("no restart", 1'b1, run_oe)
    @(posedge sys_clk_in);
    von <= 1'b1;
    cyc(8);
    `CHK("restart", 1'b0, run_oe)
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      ext_ok <= i[0];
      v7 <= i[1];
      cyc(8);
      `CHK("ext sel", (i == 3), ext_sel)
    end
    @(posedge sys_clk_in);
    rstn <= 1'b0;
    vpres <= 1'b0;
    fline <= 1'b0;
    cyc(4);
    @(posedge sys_clk_in);
    rstn <= 1'b1;
    wr_reg(8'h00, 16'h0008);
    @(posedge sys_clk_in);
    vpres <= 1'b1;
    cyc(8);
    rd_reg(8'h14, d);
    `CHK("pwrup flag", 1'b1, d[1])
    `CHK("pwrup alert", 1'b1, alert)
    @(posedge sys_clk_in);
    fline <= 1'b1;
    cyc(8);
    wr_reg(8'h14, 16'h0002);
    cyc(2);
    `CHK("alert cleared", 1'b0, alert)
    hm.pulse_stop();
    cyc(2);
    rd_reg(8'h14, d);
    `CHK("comm flag", 1'b1, d[0])
    `CHK("comm alert", 1'b1, alert)
    end_of_test();
  end
endmodule
